// File: core/pac_defines.svh
// constants for the photon autocorrelator: sizes, lags and timing
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

`define PAC_CNT_W        8
`define PAC_CNT_MAX      8'hFF
`define PAC_CW_W         16
`define PAC_NLAG         64
`define PAC_BASE_EXTRA   1024
`define PAC_BASE_LAG     (`PAC_NLAG + `PAC_BASE_EXTRA)
`define PAC_HIST_DEPTH   1088
`define PAC_HIST_AW      11
`define PAC_NACC         65
`define PAC_ACC_W        48
`define PAC_IDX_W        7
`define PAC_RATE_W       32
`define PAC_FIFO_DEPTH   16
`define PAC_CLK_NS       10
`define PAC_RATE_WIN_NS  1000000000
`define PAC_RATE_WIN_CYC (`PAC_RATE_WIN_NS / `PAC_CLK_NS)

`endif

// File: core/pac_pkg.sv
// types shared by the photon autocorrelator
`include "pac_defines.svh"

package pac_pkg;

   typedef enum logic [0:0] {
      ENG_IDLE,
      ENG_MAC
   } pac_eng_state_type;

   typedef struct packed {
      logic [`PAC_CW_W-1:0]                          ivl_cyc;
      logic [`PAC_CNT_W-1:0]                         ivl_cnt;
      logic [31:0]                                   win_cyc;
      logic [`PAC_RATE_W-1:0]                        win_cnt;
      logic [`PAC_RATE_W-1:0]                        rate;
      logic                                          overflow;
      pac_eng_state_type                             eng;
      logic [`PAC_CNT_W-1:0]                         cur;
      logic [`PAC_HIST_AW-1:0]                       lag;
      logic [`PAC_HIST_AW-1:0]                       wp;
      logic [`PAC_HIST_DEPTH-1:0][`PAC_CNT_W-1:0]    hist;
      logic [`PAC_NACC-1:0][`PAC_ACC_W-1:0]          acc;
      logic [`PAC_ACC_W-1:0]                         rd_data;
   } pac_state_type;

endpackage

// File: core/pac_top.sv
// photon autocorrelator: interval counter, sample fifo, correlation engine
// How it works
// - pulses are counted in consecutive intervals of programmable channel width
// - 64 accumulators each add newest count times a delayed count per interval
// - accumulator k pairs the newest count with the count k+1 intervals earlier
// - a baseline accumulator pairs the newest count with one 1088 intervals earlier
// - pulses are totalled over one-second windows and the rate output updated
// - each pulse belongs to exactly one interval, with no overlap between them
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module pac_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             clear,
   // filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rp;
      logic [AW-1:0]               wp;
      logic [AW:0]                 cnt;
   } pac_fifo_state_type;

   pac_fifo_state_type s_q;
   pac_fifo_state_type s_d;
   logic               push;
   logic               pop;
   logic               full;
   logic               empty;

   // next slot of a ring of DEPTH entries, shared by both pointers
   function automatic logic [AW-1:0] ring_next(input logic [AW-1:0] p);
      return (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
   endfunction

   assign full      = (s_q.cnt == (AW+1)'(DEPTH));
   assign empty     = (s_q.cnt == '0);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = ring_next(s_q.wp);
      end
      if (pop) begin
         s_d.rp = ring_next(s_q.rp);
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + (AW+1)'(1);
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - (AW+1)'(1);
      end
      if (clear) begin
         s_d.rp  = '0;
         s_d.wp  = '0;
         s_d.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // pac_fifo

////////////////////////////////////////////////////////////////////////////////
module pac_top
   import pac_pkg::*;
#(
   parameter int unsigned RATE_WIN_CYC = `PAC_RATE_WIN_CYC
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // run control
   input  wire logic                   run_clear,
   input  wire logic [`PAC_CW_W-1:0]   chan_width,
   // discriminator
   input  wire logic                   photon_pulse,
   // readout
   input  wire logic [`PAC_IDX_W-1:0]  rd_idx,
   output logic      [`PAC_ACC_W-1:0]  rd_data_q,
   output logic      [`PAC_RATE_W-1:0] rate_q,
   output logic                        overflow_q
);

////////////////////////////////////////////////////////////////////////////////

   // index of the count taken lag intervals before the slot at wp
   function automatic logic [`PAC_HIST_AW-1:0] hist_back(
      input logic [`PAC_HIST_AW-1:0] wp,
      input logic [`PAC_HIST_AW-1:0] lag
   );
      logic [`PAC_HIST_AW:0] sum;
      sum = {1'b0, wp} + (`PAC_HIST_AW+1)'(`PAC_HIST_DEPTH) - {1'b0, lag};
      if (sum >= (`PAC_HIST_AW+1)'(`PAC_HIST_DEPTH)) begin
         sum = sum - (`PAC_HIST_AW+1)'(`PAC_HIST_DEPTH);
      end
      return sum[`PAC_HIST_AW-1:0];
   endfunction

   function automatic logic [`PAC_ACC_W-1:0] mac(
      input logic [`PAC_ACC_W-1:0] acc,
      input logic [`PAC_CNT_W-1:0] a,
      input logic [`PAC_CNT_W-1:0] b
   );
      logic [2*`PAC_CNT_W-1:0] prod;
      logic [`PAC_ACC_W:0]     sum;
      prod = (2*`PAC_CNT_W)'(a) * (2*`PAC_CNT_W)'(b);
      sum  = {1'b0, acc} + (`PAC_ACC_W+1)'(prod);
      // a sum that would wrap sticks at full scale rather than reading small
      if (sum[`PAC_ACC_W]) begin
         sum = {1'b0, {`PAC_ACC_W{1'b1}}};
      end
      return sum[`PAC_ACC_W-1:0];
   endfunction

   // accumulator fed on an engine step; anything past the short lags is the baseline
   function automatic logic [`PAC_IDX_W-1:0] acc_slot(
      input logic [`PAC_HIST_AW-1:0] lag
   );
      logic [`PAC_IDX_W-1:0] slot;
      if (lag == '0 || lag > `PAC_HIST_AW'(`PAC_NLAG)) begin
         slot = `PAC_IDX_W'(`PAC_NLAG);
      end else begin
         slot = `PAC_IDX_W'(lag - `PAC_HIST_AW'(1));
      end
      return slot;
   endfunction

////////////////////////////////////////////////////////////////////////////////

   pac_state_type           q;
   pac_state_type           d;
   logic                    ivl_end;
   logic [`PAC_CW_W-1:0]    cw_last;
   logic [`PAC_CNT_W-1:0]   ivl_total;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic [`PAC_CNT_W-1:0]   fifo_out_data;
   logic                    fifo_pop;
   logic [`PAC_NACC-1:0]    acc_en;
   logic [`PAC_CNT_W-1:0]   hist_old;
   logic [`PAC_ACC_W-1:0]   acc_sum;
   logic                    win_end;
   logic                    rd_ok;

   // a width of zero behaves as one cycle
   assign cw_last   = (chan_width == '0) ? '0 : chan_width - `PAC_CW_W'(1);
   assign ivl_end   = (q.ivl_cyc >= cw_last);
   // a pulse in the last cycle still belongs to the closing interval
   assign ivl_total = (photon_pulse && q.ivl_cnt != `PAC_CNT_MAX) ?
                      q.ivl_cnt + `PAC_CNT_W'(1) : q.ivl_cnt;
   assign fifo_pop  = (q.eng == ENG_IDLE) && !run_clear;
   assign win_end   = (q.win_cyc >= RATE_WIN_CYC - 1);
   assign rd_ok     = (rd_idx < `PAC_IDX_W'(`PAC_NACC));

   // one shared multiplier and adder; the lag counter picks which sum moves
   assign hist_old  = q.hist[hist_back(q.wp, q.lag)];
   assign acc_sum   = mac(q.acc[acc_slot(q.lag)], q.cur, hist_old);

   generate
      for (genvar k = 0; k < `PAC_NACC; k++) begin : g_acc_en
         assign acc_en[k] = (q.eng == ENG_MAC) &&
                            (acc_slot(q.lag) == `PAC_IDX_W'(k));
      end
   endgenerate

   // absorbs bursts while the engine spends 66 cycles per sample
   pac_fifo #(
      .WIDTH (`PAC_CNT_W),
      .DEPTH (`PAC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .clear     (run_clear),
      .in_valid  (ivl_end && !run_clear),
      .in_data   (ivl_total),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_pop)
   );

////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      d = q;

      // interval counting
      if (ivl_end) begin
         d.ivl_cyc = '0;
         d.ivl_cnt = '0;
      end else begin
         d.ivl_cyc = q.ivl_cyc + `PAC_CW_W'(1);
         d.ivl_cnt = ivl_total;
      end

      // a sample with no room is lost; flag it, set beats clear
      if (run_clear) begin
         d.overflow = 1'b0;
      end
      if (ivl_end && !fifo_in_ready) begin
         d.overflow = 1'b1;
      end

      // one-second rate window
      if (win_end) begin
         d.win_cyc = '0;
         d.win_cnt = '0;
         d.rate    = q.win_cnt + `PAC_RATE_W'(photon_pulse);
      end else begin
         d.win_cyc = q.win_cyc + 32'h0000_0001;
         d.win_cnt = q.win_cnt + `PAC_RATE_W'(photon_pulse);
      end

      // correlation engine: one lag per cycle, baseline last
      case (q.eng)
         ENG_IDLE: begin
            if (fifo_out_valid) begin
               d.cur = fifo_out_data;
               d.lag = `PAC_HIST_AW'(1);
               d.eng = ENG_MAC;
            end
         end
         ENG_MAC: begin
            for (int k = 0; k < `PAC_NACC; k++) begin
               if (acc_en[k]) begin
                  d.acc[k] = acc_sum;
               end
            end
            if (q.lag == `PAC_HIST_AW'(`PAC_BASE_LAG)) begin
               d.hist[q.wp] = q.cur;
               d.wp  = (q.wp == `PAC_HIST_AW'(`PAC_HIST_DEPTH - 1)) ?
                       '0 : q.wp + `PAC_HIST_AW'(1);
               d.eng = ENG_IDLE;
            end else begin
               d.lag = (q.lag == `PAC_HIST_AW'(`PAC_NLAG)) ?
                       `PAC_HIST_AW'(`PAC_BASE_LAG) : q.lag + `PAC_HIST_AW'(1);
            end
         end
         default: begin
            d.eng = ENG_IDLE;
         end
      endcase

      // run start wipes history and sums
      // the rate window free-runs so the reported rate never stalls on a clear
      if (run_clear) begin
         d.ivl_cyc = '0;
         d.ivl_cnt = '0;
         d.eng     = ENG_IDLE;
         d.lag     = '0;
         d.wp      = '0;
         d.hist    = '0;
         d.acc     = '0;
      end

      // readout, index 64 is the baseline
      if (rd_ok) begin
         d.rd_data = q.acc[rd_idx];
      end else begin
         d.rd_data = '0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

////////////////////////////////////////////////////////////////////////////////

   assign rd_data_q  = q.rd_data;
   assign rate_q     = q.rate;
   assign overflow_q = q.overflow;
endmodule // pac_top

// File: tb/pac_disc_model.sv
// discriminator model: uniform one-cycle pulses at random
`timescale 1ns/10ps
module pac_disc_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // control
   input  wire logic       en,
   input  wire logic [7:0] rnd,
   input  wire logic [7:0] dens,
   // pulse train
   output logic            photon_pulse
);
   logic hit_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) hit_q <= 1'b0;
      else hit_q <= rnd < dens;
   end
   // gate acts at once, so a run stops exactly on an interval edge
   assign photon_pulse = en & hit_q;
endmodule // pac_disc_model

// File: tb/pac_top_monitor.sv
// port checker for the photon autocorrelator
`timescale 1ns/10ps
module pac_top_monitor #(
   parameter int unsigned RATE_WIN_CYC = 20
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // run control
   input wire logic        run_clear,
   input wire logic [15:0] chan_width,
   // discriminator
   input wire logic        photon_pulse,
   // readout
   input wire logic [6:0]  rd_idx,
   input wire logic [47:0] rd_data_q,
   input wire logic [31:0] rate_q,
   input wire logic        overflow_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [31:0] win_q, pc_q, last_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         win_q <= 32'h0;
         pc_q <= 32'h0;
         last_q <= 32'h0;
      end else if (win_q == RATE_WIN_CYC - 1) begin
         win_q <= 32'h0;
         pc_q <= 32'h0;
         last_q <= pc_q + 32'(photon_pulse);
      end else begin
         win_q <= win_q + 32'h1;
         pc_q <= pc_q + 32'(photon_pulse);
      end
   end
   sequence s_clear;
      run_clear ##1 run_clear;
   endsequence
   a_rd_zero_high: assert property (rd_idx > 7'h40 |=> rd_data_q == 48'h0)
      else $error("readout beyond baseline not zero");
   a_clear_zero: assert property (s_clear |=> rd_data_q == 48'h0)
      else $error("accumulator not cleared");
   a_acc_grow: assert property (($stable(rd_idx) && !run_clear && !$past(run_clear))
      |=> rd_data_q >= $past(rd_data_q)) else $error("accumulator shrank");
   a_ovf_sticky: assert property (overflow_q && !run_clear |=> overflow_q)
      else $error("overflow flag dropped");
   a_ovf_cause: assert property ($rose(overflow_q) |-> $past(chan_width) < 16'h42)
      else $error("overflow at slow sample rate");
   a_rate_edge: assert property (!$stable(rate_q) |-> win_q == 32'h0)
      else $error("rate changed inside window");
   a_rate_value: assert property (win_q == 32'h0 |-> rate_q == last_q)
      else $error("rate differs from window total");
   a_rate_max: assert property (rate_q <= RATE_WIN_CYC)
      else $error("rate above window length");
endmodule // pac_top_monitor
bind pac_top pac_top_monitor #(.RATE_WIN_CYC(RATE_WIN_CYC)) u_mon (.*);

// File: tb/photon_autocorrelator_test.sv
// self-checking bench for the photon autocorrelator
`timescale 1ns/10ps
module photon_autocorrelator_test;
   localparam int RW = 50;
   localparam int W = 66;
   localparam int NS = 1100;
   logic        clk = 1'b0, arst_n = 1'b0, run_clear = 1'b0, en = 1'b0;
   logic        photon_pulse, overflow_q;
   logic [15:0] chan_width = 16'h0042;
   logic [6:0]  rd_idx = 7'h00;
   logic [7:0]  rnd = 8'h00, dens = 8'h50;
   logic [47:0] rd_data_q;
   logic [31:0] rate_q;
   int c[NS];
   int n_errors = 0, check_count = 0, nint = 0, e = 0, cur = 0, wsum = 0, cyc = 0;
   always #5 clk = ~clk;
   pac_disc_model model (.clk(clk), .arst_n(arst_n), .en(en), .rnd(rnd), .dens(dens),
      .photon_pulse(photon_pulse));
   pac_top #(.RATE_WIN_CYC(RW)) dut (.clk(clk), .arst_n(arst_n), .run_clear(run_clear),
      .chan_width(chan_width), .photon_pulse(photon_pulse), .rd_idx(rd_idx),
      .rd_data_q(rd_data_q), .rate_q(rate_q), .overflow_q(overflow_q));
   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic chk_acc(input logic [47:0] exp, input logic [47:0] got);
      chk("acc", exp, got);
   endtask
   task automatic chk_rate(input int exp, input logic [31:0] got);
      chk("rate", 48'(exp), 48'(got));
   endtask
   task automatic chk_flag(input logic exp, input logic got);
      chk("overflow", 48'(exp), 48'(got));
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   function automatic logic [47:0] exp_acc(input int i);
      int lag;
      logic [47:0] s;
      lag = (i < 64) ? i + 1 : 1088;
      s = 48'h0;
      if (i <= 64) for (int j = lag; j < NS; j++) s += 48'(c[j] * c[j - lag]);
      return s;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         end_sim();
      end else if (arst_n) begin
         if (e > 0 && e % RW == 0) begin
            chk_rate(wsum, rate_q);
            wsum = 0;
         end
         wsum += photon_pulse;
         cur += photon_pulse;
         if (e % W == W - 1 && nint < NS) begin
            c[nint] = cur;
            nint++;
            cur = 0;
            if (nint == NS) en <= 1'b0;
         end
         e++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(53));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      en <= 1'b1;
      fork
         forever begin
            @(posedge clk);
            rnd <= 8'($urandom);
         end
      join_none
      wait (nint == NS);
      repeat (200) @(posedge clk);
      // index 65 and 66 lie beyond the baseline and must read zero
      for (int i = 0; i < 67; i++) begin
         rd_idx <= 7'(i);
         repeat (2) @(posedge clk);
         chk_acc(exp_acc(i), rd_data_q);
      end
      chan_width <= 16'h0000;
      en <= 1'b1;
      repeat (60) @(posedge clk);
      chk_flag(1'b1, overflow_q);
      chan_width <= 16'h0042;
      en <= 1'b0;
      rd_idx <= 7'h00;
      run_clear <= 1'b1;
      repeat (3) @(posedge clk);
      run_clear <= 1'b0;
      @(posedge clk);
      chk_flag(1'b0, overflow_q);
      repeat (200) @(posedge clk);
      chk_acc(48'h0, rd_data_q);
      end_sim();
   end
endmodule // photon_autocorrelator_test
